// file: sfc_pkg.sv
package sfc_pkg;

  // Command opcodes handled by this decoder.
  localparam logic [7:0] OP_LATCH_SET   = 8'h06;
  localparam logic [7:0] OP_LATCH_CLEAR = 8'h04;
  localparam logic [7:0] OP_STAT_LO     = 8'h05;
  localparam logic [7:0] OP_STAT_HI     = 8'h35;
  localparam logic [7:0] OP_STAT_WRITE  = 8'h01;
  localparam logic [7:0] OP_VOL_ENABLE  = 8'h50;
  localparam logic [7:0] OP_READ        = 8'h03;
  localparam logic [7:0] OP_FAST_READ   = 8'h0b;
  localparam logic [7:0] OP_DUAL_OUT    = 8'h3b;
  localparam logic [7:0] OP_QUAD_OUT    = 8'h6b;
  localparam logic [7:0] OP_DUAL_IO     = 8'hbb;

  // Continuous mode is kept when the mode byte upper nibble holds this value.
  localparam logic [3:0] CONT_NIBBLE = 4'ha;

  // Status register bit positions.
  localparam int unsigned SB_BUSY    = 0;
  localparam int unsigned SB_WEL     = 1;
  localparam int unsigned SB_PROT_LO = 7;
  localparam int unsigned SB_PROT_HI = 8;
  localparam int unsigned SB_QE      = 9;
  localparam int unsigned SB_CMP     = 14;
  localparam int unsigned SB_TOP     = 15;

  // Status register reset value.
  localparam logic [15:0] STATUS_RST = 16'h0000;

  // Frame lengths in link clock edges.
  localparam logic [5:0] LEN_OPCODE  = 6'h08;
  localparam logic [5:0] LEN_SW_ONE  = 6'h10;
  localparam logic [5:0] LEN_SW_TWO  = 6'h18;
  localparam logic [5:0] LEN_SAT     = 6'h3f;

  // Phase lengths in link clock edges, minus one.
  localparam logic [4:0] LAST_OPCODE   = 5'h07;
  localparam logic [4:0] LAST_ADDR_X1  = 5'h17;
  localparam logic [4:0] LAST_ADDR_X2  = 5'h0b;
  localparam logic [4:0] LAST_DUMMY_X1 = 5'h07;
  localparam logic [4:0] LAST_MODE_X2  = 5'h03;

  // Self-timed status write cycle.
  localparam int unsigned CLK_MHZ    = 25;
  localparam int unsigned TW_US      = 1000;
  localparam int unsigned TW_CYCLES  = TW_US * CLK_MHZ;

  // Decoder states of the link domain.
  typedef enum logic [2:0] {
    SFC_OPCODE,
    SFC_ADDR,
    SFC_DUMMY,
    SFC_DATA,
    SFC_STATUS,
    SFC_SWRITE,
    SFC_IGNORE
  } sfc_state_t;

endpackage

// file: sfc_cmd.sv
// Operation
// - Opcode 06h alone in a frame sets the write-enable latch.
// - Status writes execute only while the write-enable latch is set or after opcode 50h.
// - Opcode 04h alone in a frame clears the write-enable latch.
// - Latch clear is ignored while write-in-progress is set.
// - Latch clears at reset and when a timed status write or program/erase completes.
// - Status reads work any time and repeat while chip select stays low.
// - Opcode 05h returns status bits 7..0, opcode 35h returns bits 15..8.
// - Status write 01h is accepted only with the write-enable latch set or opcode 50h armed.
// - Status write never changes bits 15, 1 and 0.
// - Status write executes only if the frame ends after 8 or 16 data bits.
// - A one-byte status write clears complement-protect and quad-enable.
// - Valid status write without 50h armed starts timed cycle with busy set, then clears latch.
// - Protect bits with write-protect pin can lock out every status write.
// - Opcode 50h lets a status write update volatile bits only in the very next frame.
// - Opcode 03h takes 3 address bytes then streams data, no dummy cycles.
// - Reads increment the address after every output byte.
// - Plain reads during a busy cycle are rejected; the cycle continues.
// - Opcode 0Bh takes address and one dummy byte, then serial data out.
// - Opcode 3Bh returns data two bits per clock on both lines.
// - Opcode 6Bh returns data four bits per clock and needs quad-enable.
// - Opcode BBh takes address and mode byte two bits per clock.
// - Mode upper nibble A makes the next frame a dual read without opcode.
// - Dual data puts odd bits on line 1, even bits on line 0.
// - Dual address puts odd bits on line 1, even bits on line 0.
module sfc_cmd #(
  parameter int unsigned TW_CYC = sfc_pkg::TW_CYCLES, // Status write cycle length in core clocks.
  parameter int unsigned MEM_AW = 24                  // Memory address width.
) (
  input  wire logic              core_clk,      // Core clock.
  input  wire logic              reset_n,       // Synchronous reset, active low.
  input  wire logic              link_clk,      // Serial clock from the host.
  input  wire logic              cs_n,          // Chip select, active low.
  input  wire logic [3:0]        data_line_in,  // Levels seen on the four data lines.
  output logic      [3:0]        data_line_out, // Levels driven on the data lines.
  output logic      [3:0]        data_line_oe_n,// Line drive enables, low drives.
  input  wire logic              wp_n,          // Write-protect pin, active low.
  input  wire logic              ext_busy,      // Program or erase running elsewhere.
  input  wire logic              ext_done,      // Program or erase finished, one pulse.
  output logic      [MEM_AW-1:0] mem_addr,      // Array read address, link domain.
  input  wire logic [7:0]        mem_rdata,     // Array byte at mem_addr.
  output logic      [15:0]       status,        // Current status register.
  output logic                   cont_mode      // Continuous dual read armed.
);

  // ---------------- Link domain ----------------
  sfc_pkg::sfc_state_t st_q, st_d;
  logic              first_q;
  logic [4:0]        cnt_q, cnt_d;
  logic [7:0]        op_q, op_d;
  logic [5:0]        tot_q;
  logic [23:0]       addr_sh_q;
  logic [MEM_AW-1:0] addr_q;
  logic [15:0]       sw_q;
  logic [1:0]        wid_q, wid_d;
  logic              dual_in_q, dual_in_d;
  logic              cont_q;
  logic              ld_q, ld_d;
  logic              oe_q, oe_d;
  logic [7:0]        mode_sh_q;
  logic [15:0]       stat_s1_q, stat_s2_q;
  logic              rst_s1_q, rst_s2_q;
  logic [7:0]        out_sh_q;

  // A new frame is marked while chip select is high; the clock stands still then.
  always_ff @(posedge link_clk or posedge cs_n) begin
    if (cs_n) begin
      first_q <= 1'b1;
    end else begin
      first_q <= 1'b0;
    end
  end

  // Status and reset cross into the link domain through two flip-flops.
  always_ff @(posedge link_clk) begin
    stat_s1_q <= status;
    stat_s2_q <= stat_s1_q;
    rst_s1_q  <= reset_n;
    rst_s2_q  <= rst_s1_q;
  end

  wire        st_eff_op  = first_q ? 1'b1 : (st_q == sfc_pkg::SFC_OPCODE);
  wire [4:0]  cnt_eff    = first_q ? 5'h00 : cnt_q;
  wire [7:0]  op_sh      = {op_q[6:0], data_line_in[0]};
  wire [7:0]  op_now     = first_q ? {7'h00, data_line_in[0]} : op_sh;
  wire        busy_l     = stat_s2_q[sfc_pkg::SB_BUSY];
  wire        qe_l       = stat_s2_q[sfc_pkg::SB_QE];
  wire [23:0] addr_x1    = {addr_sh_q[22:0], data_line_in[0]};
  wire [23:0] addr_x2    = {addr_sh_q[21:0], data_line_in[1:0]};
  wire [23:0] addr_nx    = dual_in_q ? addr_x2 : addr_x1;
  wire [7:0]  mode_nx    = {mode_sh_q[5:0], data_line_in[1:0]};
  wire [4:0]  byte_last  = (wid_q == 2'd2) ? 5'h01 : ((wid_q == 2'd1) ? 5'h03 : 5'h07);
  wire        cont_frame = first_q && cont_q;

  // Next-state decode of the link-side command sequencer.
  always_comb begin
    st_d      = st_q;
    cnt_d     = cnt_eff + 5'h01;
    op_d      = op_q;
    wid_d     = wid_q;
    dual_in_d = dual_in_q;
    ld_d      = 1'b0;
    oe_d      = oe_q;
    if (cont_frame) begin
      st_d      = sfc_pkg::SFC_ADDR;
      op_d      = sfc_pkg::OP_DUAL_IO;
      dual_in_d = 1'b1;
      wid_d     = 2'd1;
      oe_d      = 1'b0;
      cnt_d     = 5'h01;
    end else if (st_eff_op) begin
      op_d  = op_now;
      st_d  = sfc_pkg::SFC_OPCODE;
      oe_d  = 1'b0;
      if (first_q) begin
        dual_in_d = 1'b0;
        wid_d     = 2'd0;
      end
      if (cnt_eff == sfc_pkg::LAST_OPCODE) begin
        cnt_d = 5'h00;
        case (op_now)
          sfc_pkg::OP_STAT_LO, sfc_pkg::OP_STAT_HI: begin
            st_d = sfc_pkg::SFC_STATUS;
            ld_d = 1'b1;
            oe_d = 1'b1;
          end
          sfc_pkg::OP_STAT_WRITE: st_d = sfc_pkg::SFC_SWRITE;
          sfc_pkg::OP_READ, sfc_pkg::OP_FAST_READ, sfc_pkg::OP_DUAL_OUT: begin
            st_d  = busy_l ? sfc_pkg::SFC_IGNORE : sfc_pkg::SFC_ADDR;
            wid_d = (op_now == sfc_pkg::OP_DUAL_OUT) ? 2'd1 : 2'd0;
          end
          sfc_pkg::OP_QUAD_OUT: begin
            st_d  = (busy_l || !qe_l) ? sfc_pkg::SFC_IGNORE : sfc_pkg::SFC_ADDR;
            wid_d = 2'd2;
          end
          sfc_pkg::OP_DUAL_IO: begin
            st_d      = busy_l ? sfc_pkg::SFC_IGNORE : sfc_pkg::SFC_ADDR;
            dual_in_d = 1'b1;
            wid_d     = 2'd1;
          end
          default: st_d = sfc_pkg::SFC_IGNORE;
        endcase
      end
    end else begin
      case (st_q)
        sfc_pkg::SFC_ADDR: begin
          if (cnt_q == (dual_in_q ? sfc_pkg::LAST_ADDR_X2 : sfc_pkg::LAST_ADDR_X1)) begin
            cnt_d = 5'h00;
            if (op_q == sfc_pkg::OP_READ) begin
              st_d = sfc_pkg::SFC_DATA;
              ld_d = 1'b1;
              oe_d = 1'b1;
            end else begin
              st_d = sfc_pkg::SFC_DUMMY;
            end
          end
        end
        sfc_pkg::SFC_DUMMY: begin
          if (cnt_q == (dual_in_q ? sfc_pkg::LAST_MODE_X2 : sfc_pkg::LAST_DUMMY_X1)) begin
            st_d  = sfc_pkg::SFC_DATA;
            cnt_d = 5'h00;
            ld_d  = 1'b1;
            oe_d  = 1'b1;
          end
        end
        sfc_pkg::SFC_DATA: begin
          if (cnt_q == byte_last) begin
            cnt_d = 5'h00;
            ld_d  = 1'b1;
          end
        end
        sfc_pkg::SFC_STATUS: begin
          if (cnt_q == sfc_pkg::LAST_OPCODE) begin
            cnt_d = 5'h00;
            ld_d  = 1'b1;
          end
        end
        sfc_pkg::SFC_SWRITE: cnt_d = 5'h00;
        sfc_pkg::SFC_IGNORE: cnt_d = 5'h00;
        default: st_d = sfc_pkg::SFC_IGNORE;
      endcase
    end
  end

  // Rising-edge sampling of the data lines and sequencer state.
  always_ff @(posedge link_clk) begin
    st_q      <= st_d;
    cnt_q     <= cnt_d;
    op_q      <= op_d;
    wid_q     <= wid_d;
    dual_in_q <= dual_in_d;
    ld_q      <= ld_d;
    oe_q      <= oe_d;
    tot_q     <= first_q ? 6'h01 : ((tot_q == sfc_pkg::LEN_SAT) ? tot_q : tot_q + 6'h01);
    if (st_d == sfc_pkg::SFC_ADDR || (!st_eff_op && st_q == sfc_pkg::SFC_ADDR)) begin
      addr_sh_q <= (st_eff_op && !cont_frame) ? 24'h000000 : addr_nx;
    end
    if (st_q == sfc_pkg::SFC_ADDR && st_d != sfc_pkg::SFC_ADDR && !st_eff_op) begin
      addr_q <= addr_nx[MEM_AW-1:0];
    end else if (st_q == sfc_pkg::SFC_DATA && ld_d && !st_eff_op) begin
      addr_q <= addr_q + {{(MEM_AW-1){1'b0}}, 1'b1};
    end
    if (!st_eff_op && st_q == sfc_pkg::SFC_DUMMY && dual_in_q) begin
      mode_sh_q <= mode_nx;
    end
    if (!rst_s2_q) begin
      cont_q <= 1'b0;
    end else if (!st_eff_op && st_q == sfc_pkg::SFC_DUMMY && dual_in_q && st_d == sfc_pkg::SFC_DATA) begin
      cont_q <= (mode_nx[7:4] == sfc_pkg::CONT_NIBBLE);
    end
    if (st_eff_op) begin
      sw_q <= 16'h0000;
    end else if (st_q == sfc_pkg::SFC_SWRITE) begin
      sw_q <= {sw_q[14:0], data_line_in[0]};
    end
  end

  // Byte to send next: array data or the selected status half.
  wire [7:0] stat_byte = (op_q == sfc_pkg::OP_STAT_HI) ? stat_s2_q[15:8] : stat_s2_q[7:0];
  wire [7:0] next_byte = (st_q == sfc_pkg::SFC_STATUS) ? stat_byte : mem_rdata;
  wire [7:0] shifted   = (wid_q == 2'd2) ? {out_sh_q[3:0], 4'h0} :
                         ((wid_q == 2'd1) ? {out_sh_q[5:0], 2'b00} : {out_sh_q[6:0], 1'b0});
  wire [7:0] cur_byte  = ld_q ? next_byte : shifted;
  wire [3:0] lines_out = (wid_q == 2'd2) ? cur_byte[7:4] :
                         ((wid_q == 2'd1) ? {2'b00, cur_byte[7:6]} : {2'b00, cur_byte[7], 1'b0});
  wire [3:0] lines_en  = (wid_q == 2'd2) ? 4'hf : ((wid_q == 2'd1) ? 4'h3 : 4'h2);

  // Falling-edge shifting of output data; lines release while chip select is high.
  always_ff @(negedge link_clk or posedge cs_n) begin
    if (cs_n) begin
      out_sh_q       <= 8'h00;
      data_line_out  <= 4'h0;
      data_line_oe_n <= 4'hf;
    end else begin
      out_sh_q       <= cur_byte;
      data_line_out  <= lines_out;
      data_line_oe_n <= oe_q ? ~lines_en : 4'hf;
    end
  end

  assign mem_addr  = addr_q;
  assign cont_mode = cont_q;

  // ---------------- Core domain ----------------
  logic        cs_s1_q, cs_s2_q, cs_s3_q;
  logic        wp_s1_q, wp_s2_q;
  logic [15:0] stat_q, stat_d;
  logic [15:0] nv_q, nv_d;
  logic        vol_arm_q, vol_arm_d;
  logic        vol_wr_q, vol_wr_d;
  logic        tbusy_q;
  logic [$clog2(TW_CYC+1)-1:0] timer_q, timer_d;
  logic [15:0] pend_q, pend_d;

  // Frame end is seen when the synchronised chip select rises.
  wire frame_end = cs_s2_q && !cs_s3_q;
  wire busy_c    = tbusy_q || ext_busy;
  wire hw_prot   = stat_q[sfc_pkg::SB_PROT_HI] ||
                   (stat_q[sfc_pkg::SB_PROT_LO] && !wp_s2_q);
  wire is_single = (tot_q == sfc_pkg::LEN_OPCODE);
  wire do_set    = frame_end && op_q == sfc_pkg::OP_LATCH_SET && is_single;
  wire do_clr    = frame_end && op_q == sfc_pkg::OP_LATCH_CLEAR && is_single && !busy_c;
  wire do_vol    = frame_end && op_q == sfc_pkg::OP_VOL_ENABLE && is_single;
  wire sw_len_ok = (tot_q == sfc_pkg::LEN_SW_ONE) || (tot_q == sfc_pkg::LEN_SW_TWO);
  wire sw_gate   = stat_q[sfc_pkg::SB_WEL] || vol_arm_q;
  wire do_sw     = frame_end && op_q == sfc_pkg::OP_STAT_WRITE && sw_len_ok && sw_gate &&
                   !hw_prot && !busy_c;
  wire [15:0] sw_full = (tot_q == sfc_pkg::LEN_SW_ONE) ?
                        {stat_q[15:8], sw_q[7:0]} : {sw_q[7:0], sw_q[15:8]};
  wire [15:0] keep_mask = (16'h0001 << sfc_pkg::SB_TOP) | (16'h0001 << sfc_pkg::SB_WEL) |
                          (16'h0001 << sfc_pkg::SB_BUSY);
  wire [15:0] one_clr   = (tot_q == sfc_pkg::LEN_SW_ONE) ?
                          ((16'h0001 << sfc_pkg::SB_CMP) | (16'h0001 << sfc_pkg::SB_QE)) : 16'h0000;
  wire [15:0] sw_val    = ((sw_full & ~keep_mask) | (stat_q & keep_mask)) & ~one_clr;
  wire        tdone     = tbusy_q && (timer_q == '0);

  // Status register, volatile arm and write cycle timer.
  always_comb begin
    stat_d    = stat_q;
    nv_d      = nv_q;
    pend_d    = pend_q;
    timer_d   = timer_q;
    vol_wr_d  = vol_wr_q;
    vol_arm_d = frame_end ? do_vol : vol_arm_q;
    if (do_sw && vol_arm_q) begin
      stat_d = sw_val;
    end else if (do_sw) begin
      pend_d   = sw_val;
      timer_d  = ($clog2(TW_CYC+1))'(TW_CYC);
      vol_wr_d = 1'b0;
    end
    if (tbusy_q && !tdone) begin
      timer_d = timer_q - 1'b1;
    end
    if (tdone) begin
      stat_d = (pend_q & ~keep_mask) | (stat_q & keep_mask);
      nv_d   = pend_q;
      stat_d[sfc_pkg::SB_WEL] = 1'b0;
    end
    if (ext_done || do_clr) begin
      stat_d[sfc_pkg::SB_WEL] = 1'b0;
    end
    if (do_set) begin
      stat_d[sfc_pkg::SB_WEL] = 1'b1;
    end
    stat_d[sfc_pkg::SB_BUSY] = (tbusy_q && !tdone) || (do_sw && !vol_arm_q) || ext_busy;
  end

  // Core registers; reset clears the latch and the busy flag.
  always_ff @(posedge core_clk) begin
    cs_s1_q <= cs_n;
    cs_s2_q <= cs_s1_q;
    cs_s3_q <= cs_s2_q;
    wp_s1_q <= wp_n;
    wp_s2_q <= wp_s1_q;
    if (!reset_n) begin
      stat_q    <= sfc_pkg::STATUS_RST;
      nv_q      <= sfc_pkg::STATUS_RST;
      pend_q    <= 16'h0000;
      timer_q   <= '0;
      tbusy_q   <= 1'b0;
      vol_arm_q <= 1'b0;
      vol_wr_q  <= 1'b0;
    end else begin
      stat_q    <= stat_d;
      nv_q      <= nv_d;
      pend_q    <= pend_d;
      timer_q   <= timer_d;
      tbusy_q   <= (tbusy_q && !tdone) || (do_sw && !vol_arm_q);
      vol_arm_q <= vol_arm_d;
      vol_wr_q  <= vol_wr_d;
    end
  end

  assign status = stat_q;

endmodule

// file: sfc_cmd_properties.sv
module sfc_cmd_checker #(
  parameter int unsigned TW_CYC = sfc_pkg::TW_CYCLES // Status write cycle in core clocks.
) (
  input wire logic        core_clk,       // Core clock.
  input wire logic        reset_n,        // Synchronous reset.
  input wire logic        link_clk,       // Host serial clock.
  input wire logic        cs_n,           // Chip select.
  input wire logic [3:0]  data_line_oe_n, // Line drive enables.
  input wire logic        ext_busy,       // Outside operation running.
  input wire logic        ext_done,       // Outside operation finished.
  input wire logic [15:0] status,         // Status register.
  input wire logic        cont_mode       // Continuous read armed.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] busy_cnt_q;
  logic [15:0] busy_cnt_d;

  // Counts the self-timed part of a busy stretch; outside work restarts the count.
  assign busy_cnt_d = (status[0] && !ext_busy) ? busy_cnt_q + 16'h0001 : 16'h0000;
  always_ff @(posedge core_clk) begin
    busy_cnt_q <= reset_n ? busy_cnt_d : 16'h0000;
  end

  a_lines_released: assert property (@(posedge core_clk) disable iff (!reset_n)
    cs_n |-> data_line_oe_n == 4'hf) else $error("lines driven outside a frame");
  a_busy_from_ext: assert property (@(posedge core_clk) disable iff (!reset_n)
    $rose(ext_busy) |-> ##[1:4] status[0]) else $error("busy flag missed outside work");
  a_done_clears: assert property (@(posedge core_clk) disable iff (!reset_n)
    ext_done |-> ##[1:4] !status[1]) else $error("latch kept after completion");
  a_cycle_holds: assert property (@(posedge core_clk) disable iff (!reset_n)
    $rose(status[0]) && !ext_busy |-> status[0] [*8]) else $error("write cycle too short");
  a_cycle_bound: assert property (@(posedge core_clk) disable iff (!reset_n)
    !ext_busy |-> busy_cnt_q <= TW_CYC + 4) else $error("write cycle too long");
  a_frozen_busy: assert property (@(posedge core_clk) disable iff (!reset_n)
    status[0] && $past(status[0]) |-> status[15:2] == $past(status[15:2]))
    else $error("status changed while busy");
  a_latch_rise: assert property (@(posedge core_clk) disable iff (!reset_n)
    $rose(status[1]) |-> $past(cs_n) && $past(cs_n, 2)) else $error("latch set inside a frame");
  a_line_pair: assert property (@(negedge link_clk) disable iff (cs_n)
    !data_line_oe_n[0] |-> !data_line_oe_n[1]) else $error("line 0 driven alone");
  a_quad_gate: assert property (@(negedge link_clk) disable iff (cs_n)
    !data_line_oe_n[3] |-> status[9]) else $error("quad data without quad enable");

  // Main scenarios reached.
  c_latch: cover property (@(posedge core_clk) disable iff (!reset_n) $rose(status[1]));
  c_cont: cover property (@(posedge link_clk) disable iff (!reset_n) $rose(cont_mode));
  c_quad: cover property (@(negedge link_clk) disable iff (cs_n) data_line_oe_n == 4'h0);
endmodule

bind sfc_cmd sfc_cmd_checker #(.TW_CYC(TW_CYC)) i_sfc_cmd_checker (
  .core_clk(core_clk), .reset_n(reset_n), .link_clk(link_clk), .cs_n(cs_n),
  .data_line_oe_n(data_line_oe_n), .ext_busy(ext_busy), .ext_done(ext_done),
  .status(status), .cont_mode(cont_mode));

// file: sfc_host_model.sv
module sfc_host_model (
  output logic       link_clk, // Serial clock, still outside frames.
  output logic       cs_n,     // Chip select.
  output logic [3:0] host_drv, // Host levels on the lines.
  input  wire logic [3:0] line // Resolved line levels.
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus before the first frame; chip select rises once all processes wait for it.
  initial begin
    link_clk = 1'b0;
    cs_n = 1'b0;
    host_drv = 4'h0;
    #1 cs_n = 1'b1;
  end

  // One frame: single-line bits, dual-line bits, then n_out captures of wid bits.
  task automatic frame(input logic [47:0] tx, input int n_one, input int n_two,
                       input int n_out, input int wid, output logic [31:0] rx);
    int n_ld;
    n_ld = n_one + n_two / 2;
    rx = '0;
    cs_n = 1'b0;
    for (int i = 0; i < n_ld + n_out; i++) begin
      if (i < n_one) begin
        host_drv[0] = tx[47];
        tx = tx << 1;
      end else if (i < n_ld) begin
        host_drv[1:0] = tx[47:46];
        tx = tx << 2;
      end else begin
        host_drv = ~host_drv; // Released lines never hold the last value.
      end
      #6 link_clk = 1'b1;
      if (i >= n_ld) begin
        case (wid)
          4: rx = {rx[27:0], line};
          2: rx = {rx[29:0], line[1:0]};
          default: rx = {rx[30:0], line[1]};
        endcase
      end
      #6 link_clk = 1'b0;
    end
    #6 cs_n = 1'b1;
    host_drv = ~host_drv;
    #200; // Gap lets the core close the frame.
  endtask
endmodule

// file: serial_flash_wel_status_read_cmds_test.sv
module serial_flash_wel_status_read_cmds_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned TW = 60; // Shortened write cycle.
  logic        core_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        link_clk;
  logic        cs_n;
  logic [3:0]  host_drv;
  logic [3:0]  line;
  logic [3:0]  data_line_out;
  logic [3:0]  data_line_oe_n;
  logic        wp_n = 1'b1;
  logic        ext_busy = 1'b0;
  logic        ext_done = 1'b0;
  logic [23:0] mem_addr;
  logic [15:0] status;
  logic        cont_mode;
  logic [31:0] rx;
  logic        drv_seen = 1'b0;
  int          n_errors = 0;
  int          cmp_count = 0;

  always #20 core_clk = ~core_clk;
  // A line shows the design where it drives and the host elsewhere.
  assign line = (data_line_out & ~data_line_oe_n) | (host_drv & data_line_oe_n);
  always @(data_line_oe_n) if (data_line_oe_n !== 4'hf) drv_seen = 1'b1;

  sfc_cmd #(.TW_CYC(TW), .MEM_AW(24)) i_sfc_cmd (
    .core_clk(core_clk), .reset_n(reset_n), .link_clk(link_clk), .cs_n(cs_n),
    .data_line_in(line), .data_line_out(data_line_out), .data_line_oe_n(data_line_oe_n),
    .wp_n(wp_n), .ext_busy(ext_busy), .ext_done(ext_done), .mem_addr(mem_addr),
    .mem_rdata(mem_addr[7:0] ^ 8'h3c), .status(status), .cont_mode(cont_mode));
  sfc_host_model i_sfc_host_model (
    .link_clk(link_clk), .cs_n(cs_n), .host_drv(host_drv), .line(line));

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic test_done();
    if (n_errors == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Status is looked at mid-cycle once the frame end has landed.
  task automatic chk16(input logic [15:0] exp, input string what);
    repeat (3) @(negedge core_clk);
    check({16'h0, status}, {16'h0, exp}, what);
  endtask

  task automatic cmd(input logic [47:0] tx, input int n1);
    i_sfc_host_model.frame(tx, n1, 0, 0, 1, rx);
  endtask

  // Reads at a page edge; two bytes prove the address steps.
  task automatic rd(input logic [47:0] tx, input int n1, input int n2, input int no,
                    input int w, input string what);
    i_sfc_host_model.frame(tx, n1, n2, no, w, rx);
    check({16'h0, rx[15:0]}, {16'h0, 8'hfe ^ 8'h3c, 8'hff ^ 8'h3c}, what);
  endtask

  initial begin
    #200000;
    n_errors++;
    test_done();
  end

  initial begin
    repeat (4) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk16(16'h0000, "reset status");
    cmd({8'h04, 40'h0}, 8);
    cmd({8'h06, 40'h0}, 8);
    chk16(16'h0002, "latch set");
    @(posedge core_clk) ext_busy <= 1'b1;
    cmd({8'h04, 40'h0}, 8);
    chk16(16'h0003, "clear while busy");
    @(posedge core_clk) ext_done <= 1'b1;
    ext_busy <= 1'b0;
    @(posedge core_clk) ext_done <= 1'b0;
    chk16(16'h0000, "done clears latch");
    cmd({8'h01, 8'h1c, 32'h0}, 16);
    chk16(16'h0000, "write without latch");
    cmd({8'h06, 40'h0}, 8);
    cmd({8'h01, 8'h7f, 8'h42, 24'h0}, 24);
    chk16(16'h0003, "write cycle busy");
    i_sfc_host_model.frame({8'h05, 40'h0}, 8, 0, 16, 1, rx);
    check(rx, 32'h0303, "status low repeat");
    drv_seen = 1'b0;
    i_sfc_host_model.frame({8'h03, 24'h0000fe, 16'h0}, 32, 0, 8, 1, rx);
    check(drv_seen, 1'b0, "read while busy");
    repeat (TW) @(posedge core_clk);
    chk16(16'h427c, "status written");
    i_sfc_host_model.frame({8'h35, 40'h0}, 8, 0, 8, 1, rx);
    check(rx, 32'h42, "status high");
    rd({8'h03, 24'h0000fe, 16'h0}, 32, 0, 16, 1, "plain read");
    rd({8'h0b, 24'h0000fe, 16'h0}, 40, 0, 16, 1, "fast read");
    rd({8'h3b, 24'h0000fe, 16'h0}, 40, 0, 8, 2, "dual out read");
    rd({8'h6b, 24'h0000fe, 16'h0}, 40, 0, 4, 4, "quad out read");
    rd({8'hbb, 24'h0000fe, 8'ha0, 8'h0}, 8, 32, 8, 2, "dual io read");
    check(cont_mode, 1'b1, "mode armed");
    rd({24'h0000fe, 8'h00, 16'h0}, 0, 32, 8, 2, "read without opcode");
    check(cont_mode, 1'b0, "mode dropped");
    cmd({8'h06, 40'h0}, 8);
    cmd({8'h01, 8'h00, 32'h0}, 20);
    chk16(16'h427e, "broken write length");
    cmd({8'h01, 8'h00, 32'h0}, 16);
    repeat (TW + 4) @(posedge core_clk);
    chk16(16'h0000, "one byte write");
    drv_seen = 1'b0;
    i_sfc_host_model.frame({8'h6b, 24'h0000fe, 16'h0}, 40, 0, 4, 4, rx);
    check(drv_seen, 1'b0, "quad without enable");
    cmd({8'h50, 40'h0}, 8);
    cmd({8'h01, 8'h80, 32'h0}, 16);
    chk16(16'h0080, "volatile write");
    @(posedge core_clk) wp_n <= 1'b0;
    cmd({8'h06, 40'h0}, 8);
    cmd({8'h01, 8'h00, 32'h0}, 16);
    chk16(16'h0082, "protected write");
    test_done();
  end
endmodule
